// File: verilog/dshp_host_port.sv
// Function
// - Select pin high runs the two-wire slave; SPI held in reset.
// - Select pin low disables two-wire slave and enables SPI.
// - Shared pins are data in and clock for SPI, SDA and SCL otherwise.
// - Sample on rising serial clock, shift out on falling edge.
// - SPI frame is address, command, data: 24 clocks under one select.
// - Write done at 24th rising edge; later bits ignored.
// - Select rising before 24th edge aborts the access.
// - Read fetched at 16th rise, MSB driven at next fall.
// - Edges beyond 24th in normal read are ignored, zeros out.
// - Sample is 4-bit tag then 20-bit value, MSB first.
// - Two-wire slave takes clocks up to 400 kHz from the master.
// - Each two-wire byte is eight bits plus acknowledge clock.
// - Reads take nine clocks per byte; device drives data in step.
// - SDA is open drain plus input; SCL input only.
// - Slave address 1101000 with address pin low, 1101001 high.
// - Pointer increments per data byte, except at FIFO data register.
// - Stop resets pointer to register zero; a repeated start then read keeps it.
`timescale 1ns/100ps
`default_nettype none
module dshp_host_port
   import dshp_pkg::*;
#(
   parameter logic [7:0] RD_CODE = DSHP_RD_CODE_DEF,
   parameter logic [7:0] WR_CODE = DSHP_WR_CODE_DEF,
   parameter logic [7:0] FIFO_REG = DSHP_FIFO_REG
)
(
   input wire logic clock,
   input wire logic rst_b,
   input wire logic chip_select_bus_select_pin,
   input wire logic serial_clock_pin,
   input wire logic shared_data_in_pin,
   output logic sda_out,
   output logic sda_oe,
   input wire logic data_out_addr_select_pin,
   output logic data_out,
   output logic data_out_oe,
   output dshp_reg_req_t reg_req,
   input wire logic [7:0] reg_rdata,
   input wire logic sample_valid,
   output logic sample_ready,
   input wire dshp_sample_t sample_data,
   output logic i2c_mode
);
   typedef struct packed
   {
      logic [1:0] cs_sync;
      logic [1:0] sck_sync;
      logic [1:0] sdi_sync;
      logic [1:0] adr_sync;
      logic sck_last;
      logic sdi_last;
      logic [5:0] bit_cnt;
      logic [7:0] shift_in;
      logic [7:0] spi_addr;
      logic spi_rd;
      logic spi_wr;
      logic burst;
      logic [23:0] shift_out;
      logic done;
      logic do_bit;
      dshp_i2c_st_t ist;
      logic [3:0] ibit;
      logic is_read;
      logic [7:0] ptr;
      logic sda_low;
      dshp_reg_req_t req;
   } dshp_port_state_t;

   dshp_port_state_t s_reg;
   dshp_port_state_t s_next;
   logic cs_lvl;
   logic sck_rise;
   logic sck_fall;
   logic start_cond;
   logic stop_cond;
   logic buf_valid;
   logic buf_pop;
   logic [23:0] buf_data;
   logic [6:0] my_addr;

   // Pointer steps unless it sits on the FIFO data register
   function automatic logic [7:0] next_ptr(input logic [7:0] p);
      next_ptr = (p == FIFO_REG) ? p : p + 8'h01;
   endfunction

   dshp_skid_buf #(
      .WIDTH(DSHP_FIFO_WORD_BITS)
   ) u_buf (
      .clock(clock),
      .rst_b(rst_b),
      .in_valid(sample_valid),
      .in_ready(sample_ready),
      .in_data(sample_data),
      .out_valid(buf_valid),
      .out_ready(buf_pop),
      .out_data(buf_data)
   );

   assign cs_lvl = s_reg.cs_sync[1];
   assign sck_rise = s_reg.sck_sync[1] && !s_reg.sck_last;
   assign sck_fall = !s_reg.sck_sync[1] && s_reg.sck_last;
   assign start_cond = s_reg.sck_sync[1] && s_reg.sck_last &&
      s_reg.sdi_last && !s_reg.sdi_sync[1];
   assign stop_cond = s_reg.sck_sync[1] && s_reg.sck_last &&
      !s_reg.sdi_last && s_reg.sdi_sync[1];
   assign my_addr = DSHP_I2C_ADDR_BASE | {6'h00, s_reg.adr_sync[1]};
   assign buf_pop = !cs_lvl && s_reg.burst && sck_fall &&
      s_reg.do_bit;
   assign i2c_mode = cs_lvl;
   assign sda_out = 1'b0;
   assign sda_oe = cs_lvl && s_reg.sda_low;
   assign data_out = s_reg.shift_out[23];
   assign data_out_oe = !cs_lvl;
   assign reg_req = s_reg.req;

   always_comb
   begin
      s_next = s_reg;
      s_next.cs_sync = {s_reg.cs_sync[0], chip_select_bus_select_pin};
      s_next.sck_sync = {s_reg.sck_sync[0], serial_clock_pin};
      s_next.sdi_sync = {s_reg.sdi_sync[0], shared_data_in_pin};
      s_next.adr_sync = {s_reg.adr_sync[0], data_out_addr_select_pin};
      s_next.sck_last = s_reg.sck_sync[1];
      s_next.sdi_last = s_reg.sdi_sync[1];
      s_next.req.wr = 1'b0;
      s_next.req.rd = 1'b0;
      if (cs_lvl)
      begin
         // SPI side held cleared, select high also aborts
         s_next.bit_cnt = '0;
         s_next.done = 1'b0;
         s_next.burst = 1'b0;
         // Keep the two-wire read byte while a transfer runs
         if (s_reg.ist == DSHP_I2C_IDLE)
         begin
            s_next.shift_out = '0;
         end
         s_next.do_bit = 1'b0;
         if (start_cond)
         begin
            s_next.ist = DSHP_I2C_ADDR;
            s_next.ibit = '0;
            s_next.sda_low = 1'b0;
         end
         else if (stop_cond)
         begin
            s_next.ist = DSHP_I2C_IDLE;
            s_next.sda_low = 1'b0;
         end
         else if (s_reg.ist != DSHP_I2C_IDLE && sck_rise)
         begin
            // Ninth clock is the acknowledge slot
            if (s_reg.ibit == 4'h8)
            begin
               if (s_reg.ist == DSHP_I2C_RDATA && s_reg.sdi_sync[1])
               begin
                  s_next.ist = DSHP_I2C_SKIP;
               end
               s_next.ibit = '0;
            end
            else
            begin
               s_next.shift_in = {s_reg.shift_in[6:0], s_reg.sdi_sync[1]};
               s_next.ibit = s_reg.ibit + 4'h1;
            end
         end
         else if (s_reg.ist != DSHP_I2C_IDLE && sck_fall)
         begin
            s_next.sda_low = 1'b0;
            if (s_reg.ibit == 4'h8)
            begin
               unique case (s_reg.ist)
                  DSHP_I2C_ADDR:
                  begin
                     if (s_reg.shift_in[7:1] == my_addr)
                     begin
                        s_next.sda_low = 1'b1;
                        s_next.is_read = s_reg.shift_in[0];
                        s_next.ist = s_reg.shift_in[0] ?
                           DSHP_I2C_RDATA : DSHP_I2C_PTR;
                     end
                     else
                     begin
                        s_next.ist = DSHP_I2C_SKIP;
                     end
                  end
                  DSHP_I2C_PTR:
                  begin
                     s_next.ptr = s_reg.shift_in;
                     s_next.sda_low = 1'b1;
                     s_next.ist = DSHP_I2C_WDATA;
                  end
                  DSHP_I2C_WDATA:
                  begin
                     s_next.req.wr = 1'b1;
                     s_next.req.addr = s_reg.ptr;
                     s_next.req.wdata = s_reg.shift_in;
                     s_next.ptr = next_ptr(s_reg.ptr);
                     s_next.sda_low = 1'b1;
                  end
                  DSHP_I2C_RDATA:
                  begin
                  end
                  DSHP_I2C_SKIP:
                  begin
                  end
                  DSHP_I2C_IDLE:
                  begin
                  end
               endcase
            end
            else if (s_reg.ist == DSHP_I2C_RDATA)
            begin
               if (s_reg.ibit == 4'h0)
               begin
                  s_next.shift_out[23:16] = reg_rdata;
                  s_next.sda_low = !reg_rdata[7];
                  s_next.ptr = next_ptr(s_reg.ptr);
               end
               else
               begin
                  s_next.shift_out[23:16] = {s_reg.shift_out[22:16], 1'b0};
                  s_next.sda_low = !s_reg.shift_out[22];
               end
            end
         end
         // Pointer fetched combinationally by the register side
         s_next.req.rd = (s_reg.ist == DSHP_I2C_RDATA);
         s_next.req.addr = s_reg.ptr;
         // Cleared on stop so a fresh start and read begins at zero;
         // a repeated start keeps a preset pointer
         if (stop_cond)
         begin
            s_next.ptr = DSHP_PTR_RESET;
         end
      end
      else
      begin
         s_next.ist = DSHP_I2C_IDLE;
         s_next.sda_low = 1'b0;
         s_next.ptr = DSHP_PTR_RESET;
         if (sck_rise && !s_reg.done)
         begin
            s_next.shift_in = {s_reg.shift_in[6:0], s_reg.sdi_sync[1]};
            s_next.bit_cnt = s_reg.bit_cnt + 6'h01;
            if (s_reg.bit_cnt == 6'd7)
            begin
               s_next.spi_addr = {s_reg.shift_in[6:0], s_reg.sdi_sync[1]};
            end
            if (s_reg.bit_cnt == 6'(DSHP_SPI_CMD_BITS - 1))
            begin
               // Fetch at 16th edge
               s_next.spi_rd = ({s_reg.shift_in[6:0], s_reg.sdi_sync[1]}
                  == RD_CODE);
               s_next.spi_wr = ({s_reg.shift_in[6:0], s_reg.sdi_sync[1]}
                  == WR_CODE);
               s_next.burst = ({s_reg.shift_in[6:0], s_reg.sdi_sync[1]}
                  == RD_CODE) && s_reg.spi_addr == FIFO_REG;
               s_next.req.rd = 1'b1;
               s_next.req.addr = s_reg.spi_addr;
            end
            if (s_reg.bit_cnt == 6'(DSHP_SPI_FRAME_BITS - 1))
            begin
               s_next.req.wr = s_reg.spi_wr;
               s_next.req.addr = s_reg.spi_addr;
               s_next.req.wdata = {s_reg.shift_in[6:0], s_reg.sdi_sync[1]};
               s_next.done = !s_reg.burst;
            end
            // Burst words follow the first 16 clocks, 24 clocks each
            if (s_reg.burst && s_reg.bit_cnt == 6'(DSHP_SPI_CMD_BITS
               + DSHP_FIFO_WORD_BITS - 1))
            begin
               s_next.bit_cnt = 6'(DSHP_SPI_CMD_BITS);
            end
            s_next.do_bit = (s_reg.bit_cnt == 6'(DSHP_SPI_CMD_BITS - 1))
               || (s_reg.burst && s_reg.bit_cnt ==
               6'(DSHP_SPI_CMD_BITS + DSHP_FIFO_WORD_BITS - 1));
         end
         if (sck_fall)
         begin
            s_next.do_bit = 1'b0;
            if (s_reg.do_bit && s_reg.burst)
            begin
               // Empty FIFO streams zeros
               s_next.shift_out = buf_valid ? buf_data : '0;
            end
            else if (s_reg.do_bit && s_reg.spi_rd)
            begin
               s_next.shift_out = {reg_rdata, 16'h0000};
            end
            else
            begin
               s_next.shift_out = {s_reg.shift_out[22:0], 1'b0};
            end
         end
      end
   end

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         s_reg <= '0;
         s_reg.cs_sync <= 2'h3;
         s_reg.sck_sync <= 2'h3;
         s_reg.sdi_sync <= 2'h3;
         s_reg.sck_last <= 1'b1;
         s_reg.sdi_last <= 1'b1;
      end
      else
      begin
         s_reg <= s_next;
      end
   end
endmodule
`default_nettype wire

// File: shared/dshp_pkg.sv
package dshp_pkg;
   localparam int DSHP_SPI_CMD_BITS = 16;
   localparam int DSHP_SPI_FRAME_BITS = 24;
   localparam int DSHP_FIFO_WORD_BITS = 24;
   localparam int DSHP_TAG_BITS = 4;
   localparam int DSHP_VALUE_BITS = 20;
   localparam logic [6:0] DSHP_I2C_ADDR_BASE = 7'h68;
   localparam logic [7:0] DSHP_FIFO_REG = 8'h0c;
   localparam logic [7:0] DSHP_PTR_RESET = 8'h00;
   localparam logic [7:0] DSHP_RD_CODE_DEF = 8'h80;
   localparam logic [7:0] DSHP_WR_CODE_DEF = 8'h00;
   localparam logic [7:0] DSHP_STRAP_SETTLE = 8'h04;

   typedef enum logic [2:0]
   {
      DSHP_I2C_IDLE = 3'b000,
      DSHP_I2C_ADDR = 3'b001,
      DSHP_I2C_PTR = 3'b010,
      DSHP_I2C_WDATA = 3'b011,
      DSHP_I2C_RDATA = 3'b100,
      DSHP_I2C_SKIP = 3'b101
   } dshp_i2c_st_t;

   typedef struct packed
   {
      logic [DSHP_TAG_BITS-1:0] tag;
      logic [DSHP_VALUE_BITS-1:0] value;
   } dshp_sample_t;

   typedef struct packed
   {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } dshp_reg_req_t;
endpackage

// File: verilog/dshp_skid_buf.sv
`timescale 1ns/100ps
`default_nettype none
module dshp_skid_buf
   import dshp_pkg::*;
#(
   parameter int WIDTH = 24
)
(
   input wire logic clock,
   input wire logic rst_b,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   typedef struct packed
   {
      logic [1:0][WIDTH-1:0] mem;
      logic wr_ptr;
      logic rd_ptr;
      logic [1:0] count;
   } dshp_buf_state_t;

   dshp_buf_state_t state_reg;
   dshp_buf_state_t state_next;
   logic push;
   logic pop;

   assign in_ready = (state_reg.count != 2'h2);
   assign out_valid = (state_reg.count != 2'h0);
   assign out_data = state_reg.mem[state_reg.rd_ptr];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb
   begin
      state_next = state_reg;
      if (push)
      begin
         state_next.mem[state_reg.wr_ptr] = in_data;
         state_next.wr_ptr = ~state_reg.wr_ptr;
      end
      if (pop)
      begin
         state_next.rd_ptr = ~state_reg.rd_ptr;
      end
      if (push && !pop)
      begin
         state_next.count = state_reg.count + 2'h1;
      end
      else if (pop && !push)
      begin
         state_next.count = state_reg.count - 2'h1;
      end
   end

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_reg <= '0;
      end
      else
      begin
         state_reg <= state_next;
      end
   end
endmodule
`default_nettype wire

// File: verification/dshp_host_port_checker.sv
`timescale 1ns/100ps
`default_nettype none
module dshp_host_port_checker
   import dshp_pkg::*;
(
   input wire logic clock,
   input wire logic rst_b,
   input wire logic chip_select_bus_select_pin,
   input wire logic serial_clock_pin,
   input wire logic shared_data_in_pin,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic data_out_addr_select_pin,
   input wire logic data_out,
   input wire logic data_out_oe,
   input wire dshp_reg_req_t reg_req,
   input wire logic [7:0] reg_rdata,
   input wire logic sample_valid,
   input wire logic sample_ready,
   input wire dshp_sample_t sample_data,
   input wire logic i2c_mode
);
   default clocking dcb @(posedge clock);
   endclocking
   default disable iff (!rst_b);
   property p_sda_od;
      sda_oe |-> i2c_mode && sda_out == 1'b0;
   endproperty
   a_sda_od: assert property (p_sda_od)
      else $error("sda driven high");
   property p_i2c_sel;
      chip_select_bus_select_pin [*5] |=> i2c_mode && !data_out_oe;
   endproperty
   a_i2c_sel: assert property (p_i2c_sel)
      else $error("two-wire mode not entered");
   property p_spi_sel;
      !chip_select_bus_select_pin [*5] |=> !i2c_mode && !sda_oe;
   endproperty
   a_spi_sel: assert property (p_spi_sel)
      else $error("serial mode not entered");
   property p_oe_mode;
      !chip_select_bus_select_pin [*5] |=> data_out_oe;
   endproperty
   a_oe_mode: assert property (p_oe_mode)
      else $error("data out not enabled");
   property p_shift_fall;
      data_out_oe && $past(data_out_oe) && $changed(data_out)
         |-> !serial_clock_pin;
   endproperty
   a_shift_fall: assert property (p_shift_fall)
      else $error("data out moved in clock high phase");
   property p_wr_spi;
      reg_req.wr && !i2c_mode |-> serial_clock_pin
         && !chip_select_bus_select_pin;
   endproperty
   a_wr_spi: assert property (p_wr_spi)
      else $error("write outside a rising clock phase");
   property p_ack_rise;
      $rose(sda_oe) |-> !serial_clock_pin;
   endproperty
   a_ack_rise: assert property (p_ack_rise)
      else $error("sda pulled while scl high");
   property p_ack_fall;
      $fell(sda_oe) |-> !serial_clock_pin;
   endproperty
   a_ack_fall: assert property (p_ack_fall)
      else $error("sda released while scl high");
   c_wr_spi: cover property (reg_req.wr && !i2c_mode);
   c_wr_i2c: cover property (reg_req.wr && i2c_mode);
   c_ack: cover property ($rose(sda_oe));
   c_rd_i2c: cover property (reg_req.rd && i2c_mode && $rose(sda_oe));
endmodule
bind dshp_host_port dshp_host_port_checker u_chk
(
   .clock(clock), .rst_b(rst_b), .i2c_mode(i2c_mode),
   .chip_select_bus_select_pin(chip_select_bus_select_pin),
   .serial_clock_pin(serial_clock_pin), .sda_out(sda_out),
   .shared_data_in_pin(shared_data_in_pin), .sda_oe(sda_oe),
   .data_out_addr_select_pin(data_out_addr_select_pin),
   .data_out(data_out), .data_out_oe(data_out_oe), .reg_req(reg_req),
   .reg_rdata(reg_rdata), .sample_valid(sample_valid),
   .sample_ready(sample_ready), .sample_data(sample_data)
);
`default_nettype wire

// File: verification/dshp_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module dshp_host_model
(
   output logic cs,
   output logic sclk,
   output logic mo,
   input wire logic miso,
   input wire logic sda
);
   localparam int SPI_HALF = 200;
   localparam int I2C_HALF = 1250;
   initial
   begin
      cs = 1'b1;
      sclk = 1'b0;
      mo = 1'b1;
   end
   // Bits past the frame are random filler
   task automatic spi(input int n, input logic [23:0] f,
                      output logic [95:0] rx);
      rx = '0;
      sclk = 1'b0;
      cs = 1'b0;
      #SPI_HALF;
      for (int i = 0; i < n; i++)
      begin
         mo = (i < 24) ? f[23-i] : 1'($urandom);
         #SPI_HALF;
         sclk = 1'b1;
         // Late in the high phase: device sees pins a few clocks late
         #(SPI_HALF - 1);
         rx = {rx[94:0], miso};
         #1;
         sclk = 1'b0;
      end
      #SPI_HALF;
      cs = 1'b1;
      mo = ~mo;
      #(2 * SPI_HALF);
   endtask
   task automatic i2c_bit(input logic b, output logic r);
      mo = b;
      #I2C_HALF;
      sclk = 1'b1;
      #I2C_HALF;
      r = sda;
      sclk = 1'b0;
   endtask
   task automatic i2c_wr(input logic [23:0] f,
                         output logic [2:0] ack);
      logic r;
      sclk = 1'b1;
      mo = 1'b1;
      #I2C_HALF;
      mo = 1'b0;
      #I2C_HALF;
      sclk = 1'b0;
      for (int i = 0; i < 27; i++)
      begin
         i2c_bit((i % 9 == 8) ? 1'b1 : f[23-(i-i/9)], r);
         if (i % 9 == 8)
            ack[2-i/9] = ~r;
      end
      mo = 1'b0;
      #I2C_HALF;
      sclk = 1'b1;
      #I2C_HALF;
      mo = 1'b1;
      #(2 * I2C_HALF);
   endtask
   // Two data bytes; pre writes the pointer first, then a repeated start
   task automatic i2c_rd(input logic [6:0] sa, input logic pre,
                         input logic [7:0] p, output logic [15:0] rx,
                         output logic [2:0] ack);
      logic r;
      logic [7:0] b;
      rx = '0;
      ack = '0;
      for (int k = pre ? 0 : 2; k < 5; k++)
      begin
         if (k == 0 || k == 2)
         begin
            mo = 1'b1;
            #I2C_HALF;
            sclk = 1'b1;
            #I2C_HALF;
            mo = 1'b0;
            #I2C_HALF;
            sclk = 1'b0;
         end
         b = (k == 1) ? p : (k == 2) ? {sa, 1'b1} : {sa, 1'b0};
         for (int i = 0; i < 9; i++)
         begin
            // Master releases data bits, acks first byte, nacks the last
            i2c_bit((i == 8) ? (k != 3) : (k > 2 || b[7-i]), r);
            if (i < 8 && k > 2)
               rx = {rx[14:0], r};
            if (i == 8 && k < 3)
               ack[k] = ~r;
         end
      end
      mo = 1'b0;
      #I2C_HALF;
      sclk = 1'b1;
      #I2C_HALF;
      mo = 1'b1;
      #(2 * I2C_HALF);
   endtask
endmodule
`default_nettype wire

// File: verification/dual_serial_host_port_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module dual_serial_host_port_tb_top;
   import dshp_pkg::*;
   localparam logic [7:0] RD = 8'hc3;
   localparam logic [7:0] WR = 8'h5a;
   logic clock, rst_b, addr_sel, sample_valid, data_out, data_out_oe;
   logic sda_out, sda_oe, i2c_mode, sample_ready, cs, sclk, mo;
   logic [7:0] reg_rdata, a, d;
   logic [95:0] rx;
   logic [15:0] rd16;
   logic [2:0] ack;
   dshp_reg_req_t reg_req;
   dshp_sample_t sample_data;
   dshp_sample_t fq[$];
   logic [15:0] wq[$];
   int mismatches, num_checks;
   wire logic sda_wire;
   wire logic addr_pin;
   // Pull-up on the data line; master and device both pull it low
   assign sda_wire = mo & ~(sda_oe & ~sda_out);
   assign addr_pin = data_out_oe ? data_out : addr_sel;
   assign reg_rdata = reg_req.addr ^ 8'ha5;
   dshp_host_port #(.RD_CODE(RD), .WR_CODE(WR)) u_dshp_host_port
   (
      .clock(clock), .rst_b(rst_b), .chip_select_bus_select_pin(cs),
      .serial_clock_pin(sclk), .shared_data_in_pin(sda_wire),
      .sda_out(sda_out), .sda_oe(sda_oe), .data_out_addr_select_pin(addr_pin),
      .data_out(data_out), .data_out_oe(data_out_oe), .reg_req(reg_req),
      .reg_rdata(reg_rdata), .sample_valid(sample_valid),
      .sample_ready(sample_ready), .sample_data(sample_data),
      .i2c_mode(i2c_mode)
   );
   dshp_host_model u_dshp_host_model
   (
      .cs(cs), .sclk(sclk), .mo(mo), .miso(data_out), .sda(sda_wire)
   );
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic expect_wr(input logic [15:0] w, input int n);
      #1000;
      check(wq.size(), n);
      if (wq.size() > 0)
         check(wq.pop_front(), w);
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial
   begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   initial
   begin
      #2000000;
      mismatches++;
      finish_test();
   end
   always @(posedge clock)
      if (reg_req.wr === 1'b1)
         wq.push_back({reg_req.addr, reg_req.wdata});
   initial
   begin
      rst_b = 1'b0;
      addr_sel = 1'b0;
      sample_valid = 1'b0;
      sample_data = '0;
      mismatches = 0;
      num_checks = 0;
      void'($urandom(47));
      repeat (16) @(posedge clock);
      #2 rst_b = 1'b1;
      repeat (8) @(posedge clock);
      #2;
      check(sample_ready, 1'b1);
      // Full frame, frame with trailing bits, frame cut short
      for (int k = 0; k < 3; k++)
      begin
         a = 8'($urandom);
         d = 8'($urandom);
         u_dshp_host_model.spi(k == 2 ? 20 : 24 + 8 * k, {a, WR, d}, rx);
         expect_wr({a, d}, k != 2);
      end
      $display("spi write tests done");
      for (int k = 0; k < 2; k++)
      begin
         a = 8'($urandom) & 8'h07;
         u_dshp_host_model.spi(24 + 8 * k, {a, RD, 8'h00}, rx);
         check(rx[8*k +: 8], a ^ 8'ha5);
         check(k ? rx[7:0] : 8'h00, 8'h00);
         check(wq.size(), 0);
      end
      $display("spi read tests done");
      for (int k = 0; k < 8 && sample_ready === 1'b1; k++)
      begin
         @(posedge clock);
         #2;
         sample_data = dshp_sample_t'($urandom);
         sample_valid = 1'b1;
         @(posedge clock);
         #2;
         fq.push_back(sample_data);
         sample_valid = 1'b0;
      end
      check(sample_ready, 1'b0);
      // One burst drains all words plus one empty slot
      u_dshp_host_model.spi(88, {DSHP_FIFO_REG, RD, 8'h00}, rx);
      for (int j = 0; j < 3; j++)
         check(rx[71-24*j -: 24], j < fq.size() ? fq[j] : 24'h0);
      check(sample_ready, 1'b1);
      $display("burst read test done");
      for (int s = 0; s < 2; s++)
      begin
         addr_sel = s[0];
         a = 8'($urandom);
         d = 8'($urandom);
         u_dshp_host_model.i2c_wr({7'h68 | 7'(s), 1'b0, a, d}, ack);
         check(ack, 3'b111);
         expect_wr({a, d}, 1);
         u_dshp_host_model.i2c_wr({7'h68 | 7'(1 - s), 1'b0, a, d}, ack);
         check(ack, 3'b000);
         expect_wr(16'h0000, 0);
      end
      $display("two-wire write tests done");
      addr_sel = 1'b0;
      // Fresh read starts at register zero; preset to FIFO register holds
      for (int s = 0; s < 2; s++)
      begin
         a = s ? DSHP_FIFO_REG : DSHP_PTR_RESET;
         d = (a == DSHP_FIFO_REG) ? a : a + 8'h01;
         u_dshp_host_model.i2c_rd(7'h68, s[0], a, rd16, ack);
         check(ack, s ? 3'b111 : 3'b100);
         check(rd16, {a ^ 8'ha5, d ^ 8'ha5});
         check(wq.size(), 0);
      end
      $display("two-wire read tests done");
      finish_test();
   end
endmodule
`default_nettype wire
